/* src/glitch_clk_pkg.sv */
// constants and preset types shared by both ends of the glitch-free clock mux
package glitch_clk_pkg;

  // system clock period, the base for every derived count
  localparam int CLOCK_PERIOD_NS = 4;

  // half periods of the two generated source clocks
  localparam int FIRST_HALF_NS  = 12;
  localparam int SECOND_HALF_NS = 20;
  localparam logic [7:0] FIRST_HALF_CYCLES  = 8'(FIRST_HALF_NS / CLOCK_PERIOD_NS);
  localparam logic [7:0] SECOND_HALF_CYCLES = 8'(SECOND_HALF_NS / CLOCK_PERIOD_NS);

  // reset values
  localparam logic IDLE_LEVEL_DEFAULT = 1'b0;
  localparam logic GATE_RESET         = 1'b1;
  localparam logic CLOCK_RESET        = 1'b0;
  localparam logic [7:0] COUNT_RESET  = 8'h00;

  // preset configurations of the core mux
  typedef enum logic [3:0] {
    PRESET_CORE          = 4'h0,
    PRESET_PLAIN         = 4'h1,
    PRESET_GATED_RISE    = 4'h2,
    PRESET_GATED_FALL    = 4'h3,
    PRESET_MUX_FALL      = 4'h4,
    PRESET_MUX_RISE      = 4'h5,
    PRESET_SELECT_PIN    = 4'h6,
    PRESET_ASYNC_MUX     = 4'h7,
    PRESET_SELECT_PIN_CE = 4'h8
  } preset_t;

endpackage

/* src/clock_mux_if.sv */
// link between the clock source end and the glitch-free mux end
`timescale 1ns/1ps
interface clock_mux_if;
  logic firstClockIn;
  logic secondClockIn;
  logic enableLaneZero;
  logic enableLaneOne;
  logic selectLaneZero;
  logic selectLaneOne;
  logic bypassDetectZero;
  logic bypassDetectOne;
  logic startupPickFirst;
  logic startupPickSecond;

  modport mux (
    input firstClockIn,
    input secondClockIn,
    input enableLaneZero,
    input enableLaneOne,
    input selectLaneZero,
    input selectLaneOne,
    input bypassDetectZero,
    input bypassDetectOne,
    input startupPickFirst,
    input startupPickSecond
  );

  modport source (
    output firstClockIn,
    output secondClockIn,
    output enableLaneZero,
    output enableLaneOne,
    output selectLaneZero,
    output selectLaneOne,
    output bypassDetectZero,
    output bypassDetectOne,
    output startupPickFirst,
    output startupPickSecond
  );
endinterface

/* src/clock_lane.sv */
// one input lane: clock synchroniser, edge detect, gate and hand-over state
`timescale 1ns/1ps
module clock_lane (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic clockPin,
  input  wire logic idleHigh,
  input  wire logic want,
  input  wire logic gateReq,
  input  wire logic bypass,
  input  wire logic allowEngage,
  input  wire logic startEngaged,
  output logic      clockLevel,
  output logic      engaged,
  output logic      gate
);

  logic syncFirst;
  logic lastLevel;
  logic riseEvt;
  logic fallEvt;
  logic switchEdge;
  logic gateEdge;
  logic gateHeld;

  ////////////////////////////////////////////////////////////////////////////
  // pin is asynchronous to the system clock
  always_ff @(posedge clock) begin
    if (rst) begin
      syncFirst  <= glitch_clk_pkg::CLOCK_RESET;
      clockLevel <= glitch_clk_pkg::CLOCK_RESET;
      lastLevel  <= glitch_clk_pkg::CLOCK_RESET;
    end else begin
      syncFirst  <= clockPin;
      clockLevel <= syncFirst;
      lastLevel  <= clockLevel;
    end
  end

  assign riseEvt = clockLevel & ~lastLevel;
  assign fallEvt = ~clockLevel & lastLevel;
  // idle low: hand-over on falling, gate on rising; idle high swaps them
  assign switchEdge = idleHigh ? riseEvt : fallEvt;
  assign gateEdge   = idleHigh ? fallEvt : riseEvt;

  ////////////////////////////////////////////////////////////////////////////
  // gate only moves on its own edge, so a pulse under way always completes
  always_ff @(posedge clock) begin
    if (rst) begin
      gateHeld <= glitch_clk_pkg::GATE_RESET;
    end else if (gateEdge) begin
      gateHeld <= gateReq;
    end
  end

  // new enable acts in the edge cycle itself, else the pulse start is cut
  assign gate = gateEdge ? gateReq : gateHeld;

  ////////////////////////////////////////////////////////////////////////////
  // lane state lives in the lane's own edge timing, except under bypass, which acts in any cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      engaged <= startEngaged;
    end else if (bypass && !want) begin
      engaged <= 1'b0;
    end else if (bypass && want && allowEngage) begin
      engaged <= 1'b1;
    end else if (switchEdge) begin
      engaged <= want && (engaged || allowEngage);
    end
  end

endmodule

/* src/glitch_free_clock_mux_core.sv */
// glitch-free two-input clock mux with preset configurations
`timescale 1ns/1ps
module glitch_free_clock_mux_core #(
  parameter glitch_clk_pkg::preset_t PRESET     = glitch_clk_pkg::PRESET_CORE,
  parameter logic                    IDLE_LEVEL = glitch_clk_pkg::IDLE_LEVEL_DEFAULT
) (
  input  wire logic clock,
  input  wire logic rst,
  clock_mux_if.mux  link,
  output logic      muxedClock,
  output logic      usingFirst,
  output logic      usingSecond,
  output logic      switchPending
);

  // effective control lines after preset tie-offs
  logic ceZero;
  logic ceOne;
  logic selZero;
  logic selOne;
  logic ignZero;
  logic ignOne;
  logic pick;
  logic idleHigh;
  logic startZero;
  logic startOne;

  // lane results
  logic wantZero;
  logic wantOne;
  logic allowZero;
  logic allowOne;
  logic levelZero;
  logic levelOne;
  logic engZero;
  logic engOne;
  logic gateZero;
  logic gateOne;
  logic passZero;
  logic passOne;
  logic next_muxedClock;
  logic next_switchPending;

  ////////////////////////////////////////////////////////////////////////////
  // idle level: fixed by the plain and edge-sensitive presets, else the parameter
  always_comb begin
    case (PRESET)
      glitch_clk_pkg::PRESET_GATED_FALL: begin
        idleHigh = 1'b1;
      end
      glitch_clk_pkg::PRESET_MUX_RISE: begin
        idleHigh = 1'b1;
      end
      glitch_clk_pkg::PRESET_PLAIN,
      glitch_clk_pkg::PRESET_GATED_RISE,
      glitch_clk_pkg::PRESET_MUX_FALL: begin
        idleHigh = 1'b0;
      end
      default: begin
        idleHigh = IDLE_LEVEL;
      end
    endcase
  end

  // single select line of the mux presets rides on lane-one select
  assign pick = link.selectLaneOne;

  ////////////////////////////////////////////////////////////////////////////
  // tie unused control lines per preset
  always_comb begin
    ceZero  = link.enableLaneZero;
    ceOne   = link.enableLaneOne;
    selZero = link.selectLaneZero;
    selOne  = link.selectLaneOne;
    ignZero = link.bypassDetectZero;
    ignOne  = link.bypassDetectOne;
    case (PRESET)
      glitch_clk_pkg::PRESET_PLAIN: begin
        ceZero  = 1'b1;
        selZero = 1'b1;
        ceOne   = 1'b0;
        selOne  = 1'b0;
        ignZero = 1'b0;
        ignOne  = 1'b0;
      end
      glitch_clk_pkg::PRESET_GATED_RISE,
      glitch_clk_pkg::PRESET_GATED_FALL: begin
        selZero = 1'b1;
        ceOne   = 1'b0;
        selOne  = 1'b0;
        ignZero = 1'b0;
        ignOne  = 1'b0;
      end
      glitch_clk_pkg::PRESET_MUX_FALL,
      glitch_clk_pkg::PRESET_MUX_RISE: begin
        // enable lanes steer, so the select has enable-lane setup
        ceZero  = ~pick;
        ceOne   = pick;
        selZero = 1'b1;
        selOne  = 1'b1;
        ignZero = 1'b0;
        ignOne  = 1'b0;
      end
      glitch_clk_pkg::PRESET_SELECT_PIN: begin
        ceZero  = 1'b1;
        ceOne   = 1'b1;
        selZero = ~pick;
        selOne  = pick;
        ignZero = 1'b0;
        ignOne  = 1'b0;
      end
      glitch_clk_pkg::PRESET_ASYNC_MUX: begin
        ceZero  = 1'b1;
        ceOne   = 1'b1;
        selZero = ~pick;
        selOne  = pick;
        ignZero = 1'b1;
        ignOne  = 1'b1;
      end
      glitch_clk_pkg::PRESET_SELECT_PIN_CE: begin
        ceZero  = link.enableLaneZero;
        ceOne   = link.enableLaneZero;
        selZero = ~pick;
        selOne  = pick;
        ignZero = 1'b0;
        ignOne  = 1'b0;
      end
      default: begin
        ceZero  = link.enableLaneZero;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // startup choice; single-input presets always start on the first input
  always_comb begin
    case (PRESET)
      glitch_clk_pkg::PRESET_PLAIN,
      glitch_clk_pkg::PRESET_GATED_RISE,
      glitch_clk_pkg::PRESET_GATED_FALL: begin
        startZero = 1'b1;
        startOne  = 1'b0;
      end
      default: begin
        // first wins should both straps arrive set
        startZero = link.startupPickFirst;
        startOne  = link.startupPickSecond & ~link.startupPickFirst;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // an input is wanted only with both lines of its pair high
  assign wantZero = selZero & ceZero;
  assign wantOne  = selOne & ceOne;

  // hand-over: a lane engages only once the other has let go; with both
  // pairs high the engaged lane keeps the output
  assign allowZero = ~engOne;
  assign allowOne  = ~engZero & ~wantZero;

  ////////////////////////////////////////////////////////////////////////////
  clock_lane laneZero (
    .clock        (clock),
    .rst          (rst),
    .clockPin     (link.firstClockIn),
    .idleHigh     (idleHigh),
    .want         (wantZero),
    .gateReq      (ceZero),
    .bypass       (ignZero),
    .allowEngage  (allowZero),
    .startEngaged (startZero),
    .clockLevel   (levelZero),
    .engaged      (engZero),
    .gate         (gateZero)
  );

  clock_lane laneOne (
    .clock        (clock),
    .rst          (rst),
    .clockPin     (link.secondClockIn),
    .idleHigh     (idleHigh),
    .want         (wantOne),
    .gateReq      (ceOne),
    .bypass       (ignOne),
    .allowEngage  (allowOne),
    .startEngaged (startOne),
    .clockLevel   (levelOne),
    .engaged      (engOne),
    .gate         (gateOne)
  );

  ////////////////////////////////////////////////////////////////////////////
  // a lane passes its clock only while engaged and gated; idle low ORs
  // high phases, idle high ORs low phases, so nothing rests in between
  assign passZero = engZero & gateZero;
  assign passOne  = engOne & gateOne;

  always_comb begin
    if (idleHigh) begin
      next_muxedClock = ~((passZero & ~levelZero) | (passOne & ~levelOne));
    end else begin
      next_muxedClock = (passZero & levelZero) | (passOne & levelOne);
    end
  end

  // registered so the output cannot glitch between lane updates
  always_ff @(posedge clock) begin
    if (rst) begin
      muxedClock <= IDLE_LEVEL;
    end else begin
      muxedClock <= next_muxedClock;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status: which input drives, and whether a hand-over is under way
  assign next_switchPending = (wantZero & ~engZero & ~engOne)
                            | (wantOne & ~engOne & ~wantZero)
                            | (engZero & ~wantZero)
                            | (engOne & ~wantOne);

  always_ff @(posedge clock) begin
    if (rst) begin
      usingFirst    <= 1'b0;
      usingSecond   <= 1'b0;
      switchPending <= 1'b0;
    end else begin
      usingFirst    <= engZero;
      usingSecond   <= engOne;
      switchPending <= next_switchPending;
    end
  end

endmodule

/* src/clock_source_end.sv */
// source end: generates both clocks and drives the mux control lines
`timescale 1ns/1ps
module clock_source_end (
  input  wire logic   clock,
  input  wire logic   rst,
  clock_mux_if.source link,
  input  wire logic   runFirst,
  input  wire logic   runSecond,
  input  wire logic   pickSecond,
  input  wire logic   gateEnable,
  input  wire logic   forceBypass,
  input  wire logic   pickFirstAtStart,
  input  wire logic   pickSecondAtStart
);

  logic [7:0] countFirst;
  logic [7:0] countSecond;
  logic       tickFirst;
  logic       tickSecond;
  logic       safe;
  logic       heldPick;
  logic       heldGate;

  assign tickFirst  = countFirst == glitch_clk_pkg::FIRST_HALF_CYCLES - 8'h01;
  assign tickSecond = countSecond == glitch_clk_pkg::SECOND_HALF_CYCLES - 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // half-period dividers; a stopped clock holds its level
  always_ff @(posedge clock) begin
    if (rst || tickFirst) begin
      countFirst <= glitch_clk_pkg::COUNT_RESET;
    end else begin
      countFirst <= countFirst + 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || tickSecond) begin
      countSecond <= glitch_clk_pkg::COUNT_RESET;
    end else begin
      countSecond <= countSecond + 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      link.firstClockIn  <= glitch_clk_pkg::CLOCK_RESET;
      link.secondClockIn <= glitch_clk_pkg::CLOCK_RESET;
    end else begin
      if (tickFirst && runFirst) begin
        link.firstClockIn <= ~link.firstClockIn;
      end
      if (tickSecond && runSecond) begin
        link.secondClockIn <= ~link.secondClockIn;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // controls only move in a cycle with no clock edge next, keeping setup
  assign safe = ~tickFirst & ~tickSecond;

  always_ff @(posedge clock) begin
    if (rst) begin
      heldPick <= 1'b0;
      heldGate <= 1'b1;
    end else if (safe) begin
      heldPick <= pickSecond;
      heldGate <= gateEnable;
    end
  end

  assign link.enableLaneZero = heldGate;
  assign link.enableLaneOne  = heldGate;
  assign link.selectLaneZero = ~heldPick;
  assign link.selectLaneOne  = heldPick;

  // a stopped clock is bypassed, else its hand-over never finishes
  assign link.bypassDetectZero = forceBypass | ~runFirst;
  assign link.bypassDetectOne  = forceBypass | ~runSecond;

  // never both startup picks: first wins
  assign link.startupPickFirst  = pickFirstAtStart;
  assign link.startupPickSecond = pickSecondAtStart & ~pickFirstAtStart;

endmodule

/* tb/clock_mux_props.sv */
// assertions on the clock mux link and its output
`timescale 1ns/1ps
module clock_mux_props (
  input wire logic clock,
  input wire logic rst,
  input wire logic firstClockIn,
  input wire logic secondClockIn,
  input wire logic enableLaneZero,
  input wire logic enableLaneOne,
  input wire logic selectLaneZero,
  input wire logic selectLaneOne,
  input wire logic bypassDetectZero,
  input wire logic bypassDetectOne,
  input wire logic startupPickFirst,
  input wire logic startupPickSecond,
  input wire logic muxedClock,
  input wire logic usingFirst,
  input wire logic usingSecond
);
  logic [4:0] firstRun;
  logic [4:0] offRun;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  // saturating counts, so long steady spans cost no unrolling
  always_ff @(posedge clock) begin
    if (rst || !(enableLaneZero && selectLaneZero && usingFirst)) firstRun <= 5'h00;
    else if (firstRun != 5'h1f) firstRun <= firstRun + 5'h01;
  end
  always_ff @(posedge clock) begin
    if (rst || (enableLaneZero && selectLaneZero) || (enableLaneOne && selectLaneOne))
      offRun <= 5'h00;
    else if (offRun != 5'h1f) offRun <= offRun + 5'h01;
  end
  ////////////////////////////////////////////////////////////////////////
  AST_RESET_IDLE: assert property (disable iff (1'b0) rst |=> !muxedClock)
    else $error("output not at idle level in reset");
  AST_ONE_LANE: assert property (!(usingFirst && usingSecond))
    else $error("both lanes engaged");
  AST_FOLLOW_FIRST: assert property (firstRun > 5'h0f && $rose(firstClockIn)
    |-> ##[2:4] $rose(muxedClock))
    else $error("output does not follow first clock");
  // bypass drops glitch protection, so pulse widths are only judged without it
  AST_HIGH_WHOLE: assert property (disable iff (rst || bypassDetectZero || bypassDetectOne)
    $rose(muxedClock) |=> muxedClock [*2])
    else $error("short high pulse on output");
  AST_LOW_WHOLE: assert property (disable iff (rst || bypassDetectZero || bypassDetectOne)
    $fell(muxedClock) |=> !muxedClock [*2])
    else $error("short low pulse on output");
  AST_SWITCH_BOUND: assert property ($rose(selectLaneOne) && enableLaneOne
    && !bypassDetectZero && !bypassDetectOne |-> ##[1:40] usingSecond)
    else $error("switch to second not done in time");
  AST_BYPASS_AWAY: assert property ($rose(selectLaneOne) && bypassDetectZero
    |-> ##[1:3] !usingFirst)
    else $error("bypassed lane not released at once");
  AST_BYPASS_BOTH: assert property ($rose(selectLaneOne) && enableLaneOne
    && bypassDetectZero && bypassDetectOne |-> ##[1:5] usingSecond)
    else $error("both bypasses did not switch at once");
  AST_IDLE_REST: assert property (offRun > 5'h17 |-> !muxedClock)
    else $error("output toggles with no lane wanted");
  AST_ONE_STRAP: assert property (!(startupPickFirst && startupPickSecond))
    else $error("both startup picks driven");
  COVER_TO_SECOND: cover property ($rose(usingSecond));
  COVER_TO_FIRST: cover property ($rose(usingFirst));
  COVER_IDLE: cover property (offRun == 5'h1f);
  COVER_SECOND_RUN: cover property (usingSecond && $rose(secondClockIn));
endmodule

/* tb/glitch_free_clock_mux_test.sv */
// self-checking bench: source end and mux end joined by the link
`timescale 1ns/1ps
module glitch_free_clock_mux_test;
  logic clock;
  logic rst;
  logic runFirst;
  logic runSecond;
  logic pickSecond;
  logic gateEnable;
  logic forceBypass;
  logic pickFirstAtStart;
  logic pickSecondAtStart;
  logic muxedClock;
  logic usingFirst;
  logic usingSecond;
  logic riseClock;
  logic riseSecond;
  logic pending;
  int   fail_count;
  int   total_checks;
  int   len;
  clock_mux_if link ();
  clock_source_end clock_source_end_inst (.clock(clock), .rst(rst), .link(link.source),
    .runFirst(runFirst), .runSecond(runSecond), .pickSecond(pickSecond),
    .gateEnable(gateEnable), .forceBypass(forceBypass),
    .pickFirstAtStart(pickFirstAtStart), .pickSecondAtStart(pickSecondAtStart));
  glitch_free_clock_mux_core #(.PRESET(glitch_clk_pkg::PRESET_CORE), .IDLE_LEVEL(1'b0))
    glitch_free_clock_mux_core_inst (.clock(clock), .rst(rst), .link(link.mux),
    .muxedClock(muxedClock), .usingFirst(usingFirst), .usingSecond(usingSecond),
    .switchPending(pending));
  // rising-edge preset on the same link: idles high, hands over on rises
  glitch_free_clock_mux_core #(.PRESET(glitch_clk_pkg::PRESET_MUX_RISE), .IDLE_LEVEL(1'b1))
    glitch_free_clock_mux_core_rise_inst (.clock(clock), .rst(rst), .link(link.mux),
    .muxedClock(riseClock), .usingFirst(), .usingSecond(riseSecond), .switchPending());
  clock_mux_props clock_mux_props_inst (.clock(clock), .rst(rst),
    .firstClockIn(link.firstClockIn), .secondClockIn(link.secondClockIn),
    .enableLaneZero(link.enableLaneZero), .enableLaneOne(link.enableLaneOne),
    .selectLaneZero(link.selectLaneZero), .selectLaneOne(link.selectLaneOne),
    .bypassDetectZero(link.bypassDetectZero), .bypassDetectOne(link.bypassDetectOne),
    .startupPickFirst(link.startupPickFirst), .startupPickSecond(link.startupPickSecond),
    .muxedClock(muxedClock), .usingFirst(usingFirst), .usingSecond(usingSecond));
  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check_bit(input logic actual, input logic expected);
    total_checks++;
    if (actual !== expected) begin
      fail_count++;
      $display("ERROR %0t bit got %b want %b", $time, actual, expected);
    end
  endtask
  task automatic check_count(input int actual, input int expected);
    total_checks++;
    if (actual != expected) begin
      fail_count++;
      $display("ERROR %0t count got %0d want %0d", $time, actual, expected);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge clock);
  endtask
  // bounded wait for a lane to engage; running out ends the run
  task automatic wait_lane(input logic second, input int bound);
    int n;
    n = 0;
    while ((second ? usingSecond : usingFirst) !== 1'b1 && n < bound) begin
      @(negedge clock);
      n++;
    end
    check_bit(n < bound, 1'b1);
    if (n >= bound) complete_run();
  endtask
  // bounded wait for the hand-over status to show
  task automatic wait_pending(input int bound);
    int n;
    n = 0;
    while (pending !== 1'b1 && n < bound) begin
      @(negedge clock);
      n++;
    end
    check_bit(n < bound, 1'b1);
    if (n >= bound) complete_run();
  endtask
  // next whole pulse away from idle: high of the main output, low of the rising mux
  task automatic high_run(input logic alt, output int width);
    int n;
    n = 0;
    width = 0;
    while ((alt ? ~riseClock : muxedClock) !== 1'b0 && n < 60) begin
      @(negedge clock);
      n++;
    end
    while ((alt ? ~riseClock : muxedClock) !== 1'b1 && n < 60) begin
      @(negedge clock);
      n++;
    end
    while ((alt ? ~riseClock : muxedClock) === 1'b1 && width < 60) begin
      @(negedge clock);
      width++;
    end
    check_bit(n < 60, 1'b1);
    if (n >= 60) complete_run();
  endtask
  task automatic do_reset(input logic strapFirst, input logic strapSecond, input logic want);
    rst = 1'b1;
    pickFirstAtStart = strapFirst;
    pickSecondAtStart = strapSecond;
    pickSecond = want;
    cycles(5);
    check_bit(muxedClock, 1'b0);
    check_bit(riseClock, 1'b1);
    rst = 1'b0;
    cycles(3);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic test_startup();
    do_reset(1'b1, 1'b1, 1'b0);
    check_bit(usingFirst, 1'b1);
    check_bit(usingSecond, 1'b0);
    high_run(1'b0, len);
    check_count(len, int'(glitch_clk_pkg::FIRST_HALF_CYCLES));
    high_run(1'b1, len);
    check_count(len, int'(glitch_clk_pkg::FIRST_HALF_CYCLES));
  endtask
  task automatic test_gate();
    int highs;
    highs = 0;
    gateEnable = 1'b0;
    cycles(12);
    repeat (30) begin
      @(negedge clock);
      if (muxedClock !== 1'b0) highs++;
    end
    check_count(highs, 0);
    gateEnable = 1'b1;
    high_run(1'b0, len);
    check_count(len, int'(glitch_clk_pkg::FIRST_HALF_CYCLES));
  endtask
  task automatic test_switch();
    pickSecond = 1'b1;
    wait_pending(8);
    wait_lane(1'b1, 40);
    check_bit(pending, 1'b0);
    check_bit(usingFirst, 1'b0);
    high_run(1'b0, len);
    check_count(len, int'(glitch_clk_pkg::SECOND_HALF_CYCLES));
    check_bit(riseSecond, 1'b1);
    high_run(1'b1, len);
    check_count(len, int'(glitch_clk_pkg::SECOND_HALF_CYCLES));
    pickSecond = 1'b0;
    wait_lane(1'b0, 40);
    cycles(8);
  endtask
  // both bypasses: over and back at once, glitch guard off meanwhile
  task automatic test_bypass();
    forceBypass = 1'b1;
    cycles(2);
    pickSecond = 1'b1;
    wait_lane(1'b1, 8);
    pickSecond = 1'b0;
    wait_lane(1'b0, 8);
    cycles(20);
    forceBypass = 1'b0;
    cycles(20);
  endtask
  // a stopped first clock never falls; its bypass line frees the switch
  task automatic test_stopped();
    runFirst = 1'b0;
    cycles(4);
    pickSecond = 1'b1;
    wait_lane(1'b1, 30);
    check_bit(usingFirst, 1'b0);
    runFirst = 1'b1;
    cycles(30);
  endtask
  task automatic test_restart();
    do_reset(1'b0, 1'b1, 1'b1);
    check_bit(usingSecond, 1'b1);
    check_bit(usingFirst, 1'b0);
    high_run(1'b0, len);
    check_count(len, int'(glitch_clk_pkg::SECOND_HALF_CYCLES));
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    rst = 1'b1;
    runFirst = 1'b1;
    runSecond = 1'b1;
    pickSecond = 1'b0;
    gateEnable = 1'b1;
    forceBypass = 1'b0;
    pickFirstAtStart = 1'b1;
    pickSecondAtStart = 1'b1;
    fail_count = 0;
    total_checks = 0;
    @(negedge clock);
    test_startup();
    test_gate();
    test_switch();
    test_bypass();
    test_stopped();
    test_restart();
    complete_run();
  end
endmodule
